// ---- rtl/port_data_block.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "port_data_regs.svh"
module port_data_block (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire port_data_pkg::bus_req_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_pa,
  input wire logic [7:0] i_pb,
  input wire logic [7:0] i_pc,
  input wire logic [2:0] i_pd,
  output logic [7:0] o_pa,
  output logic [7:0] o_pa_oe,
  output logic [7:0] o_pb,
  output logic [7:0] o_pb_oe,
  output logic [7:0] o_pc,
  output logic [7:0] o_pc_oe,
  output logic [2:0] o_pd,
  output logic [2:0] o_pd_oe,
  output logic [7:0] o_pa_fast_slew,
  output logic [7:0] o_pb_fast_slew,
  output logic [2:0] o_pd_fast_slew,
  input wire logic [7:0] i_address_out,
  input wire logic [7:0] i_cell_clk_en,
  input wire logic [7:0] i_cell_group_low_d,
  input wire logic [7:0] i_cell_group_high_d,
  output logic [7:0] o_output_cell_group_low,
  output logic [7:0] o_output_cell_group_high,
  input wire logic [7:0] i_route_low_to_b,
  input wire logic [7:0] i_route_high_to_c,
  input wire logic [7:0] i_oe_term_a,
  input wire logic [7:0] i_oe_term_b,
  input wire logic [7:0] i_oe_term_c,
  input wire logic [2:0] i_oe_term_d,
  input wire logic [2:0] i_cs_term,
  input wire logic [2:0] i_cs_active_high,
  input wire logic [2:0] i_cs_enable,
  input wire logic [7:0] i_imc_strobe,
  input wire logic i_data_port_mode,
  input wire logic i_peripheral_mode,
  input wire logic i_periph_select,
  input wire logic [7:0] i_mcu_data,
  input wire logic i_test_port_en,
  input wire logic i_data_byte_enable_en,
  input wire logic i_power_down_active,
  output logic [23:0] o_array_inputs,
  output logic o_address_strobe,
  output logic o_logic_clock_in,
  output logic o_data_byte_enable,
  output logic o_chip_select_n,
  output logic o_mem_disable
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] out_a, out_b, out_c;
    logic [2:0] out_d;
    logic [7:0] dir_a, dir_b, dir_c;
    logic [2:0] dir_d;
    logic [7:0] mode_a, mode_b;
    logic [7:0] drv_a, drv_b, drv_c;
    logic [2:0] drv_d;
    logic [7:0] omc_low, omc_high, mask_low, mask_high;
    logic [7:0] imc_a, imc_b, imc_c;
    logic [7:0] rdata;
  } state_s;
  state_s st_r;
  state_s st_nxt;
  logic wr;
  logic rd;
  logic [7:0] drv_st_a, drv_st_b, drv_st_c;
  logic [7:0] cell_a, cell_b, cell_c;
  logic [7:0] csel_a, csel_b, csel_c;
  logic [7:0] tri_a;
  logic [7:0] lvl_a;
  logic [7:0] oe_a;
  logic [2:0] cs_level, pd_drv;
  // Chip select high shuts off the register block
  assign o_chip_select_n = i_pd[2];
  assign o_mem_disable = i_pd[2]; // see R13
  assign wr = i_bus.sel & i_bus.wr & ~i_pd[2];
  assign rd = i_bus.sel & i_bus.rd & ~i_pd[2];
  // ----------------------------------------
  // Cell routing to pins
  // ----------------------------------------
  // Low group reaches A or B, high group B or C
  always_comb begin
    csel_a = ~i_route_low_to_b; // see R8
    cell_a = st_r.omc_low;
    csel_b = i_route_low_to_b | ~i_route_high_to_c;
    cell_b = (i_route_low_to_b & st_r.omc_low) | (~i_route_high_to_c & st_r.omc_high);
    csel_c = i_route_high_to_c;
    cell_c = st_r.omc_high;
  end
  // Data port and peripheral buffer live on port A only
  always_comb begin
    tri_a = {8{i_power_down_active & (i_data_port_mode | i_peripheral_mode)}}; // see R10 see R16
    if (i_peripheral_mode & ~i_periph_select) begin
      tri_a = 8'hFF;
    end
  end
  port_pin_slice u_pa (
    .i_latch(st_r.out_a),
    .i_cell(cell_a),
    .i_cell_sel(csel_a),
    .i_addr_out(i_address_out),
    .i_addr_sel(st_r.mode_a), // see R18
    .i_dir(st_r.dir_a),
    .i_oe_term(i_oe_term_a),
    .i_open_drain(st_r.drv_a & `HIGH_NIBBLE),
    .i_tristate(tri_a),
    .o_level(lvl_a),
    .o_oe(oe_a),
    .o_drv_state(drv_st_a)
  );
  // Data and peripheral modes hand port A to the mcu bus
  assign o_pa = (i_data_port_mode | i_peripheral_mode) ? i_mcu_data : lvl_a;
  assign o_pa_oe = oe_a;
  port_pin_slice u_pb (
    .i_latch(st_r.out_b),
    .i_cell(cell_b),
    .i_cell_sel(csel_b),
    .i_addr_out(i_address_out),
    .i_addr_sel(st_r.mode_b),
    .i_dir(st_r.dir_b),
    .i_oe_term(i_oe_term_b),
    .i_open_drain(st_r.drv_b & `HIGH_NIBBLE),
    .i_tristate(`RST_BYTE),
    .o_level(o_pb),
    .o_oe(o_pb_oe),
    .o_drv_state(drv_st_b)
  );
  // Port C: no address out; test port takes the pins
  port_pin_slice u_pc (
    .i_latch(st_r.out_c),
    .i_cell(cell_c),
    .i_cell_sel(csel_c),
    .i_addr_out(`RST_BYTE),
    .i_addr_sel(`RST_BYTE), // see R11
    .i_dir(st_r.dir_c),
    .i_oe_term(i_oe_term_c),
    .i_open_drain(st_r.drv_c),
    .i_tristate({8{i_test_port_en}}),
    .o_level(o_pc),
    .o_oe(o_pc_oe),
    .o_drv_state(drv_st_c)
  );
  assign o_pa_fast_slew = st_r.drv_a & `LOW_NIBBLE; // see R9
  assign o_pb_fast_slew = st_r.drv_b & `LOW_NIBBLE;
  assign o_pd_fast_slew = st_r.drv_d;
  assign o_data_byte_enable = i_data_byte_enable_en & i_pc[7];
  // ----------------------------------------
  // Port D chip selects
  // ----------------------------------------
  // One product term each, polarity chosen per pin
  always_comb begin
    cs_level = ~(i_cs_term ^ i_cs_active_high); // see R14
    pd_drv = i_oe_term_d | st_r.dir_d; // see R15 see R17
    o_pd = (i_cs_enable & cs_level) | (~i_cs_enable & st_r.out_d);
    o_pd_oe = pd_drv;
  end
  // Port D inputs go straight to the array
  assign o_address_strobe = i_pd[0]; // see R12 see R13
  assign o_logic_clock_in = i_pd[1];
  assign o_array_inputs = {st_r.imc_c, st_r.imc_b, st_r.imc_a}; // see R5
  assign o_output_cell_group_low = st_r.omc_low;
  assign o_output_cell_group_high = st_r.omc_high;
  assign o_rdata = st_r.rdata;
  // ----------------------------------------
  // Register writes, cell loads, read data
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Array clocks cells; bus loads only unmasked bits
    st_nxt.omc_low = (i_cell_clk_en & i_cell_group_low_d) | (~i_cell_clk_en & st_r.omc_low);
    st_nxt.omc_high = (i_cell_clk_en & i_cell_group_high_d) | (~i_cell_clk_en & st_r.omc_high);
    st_nxt.imc_a = (i_imc_strobe & i_pa) | (~i_imc_strobe & st_r.imc_a); // see R5
    st_nxt.imc_b = (i_imc_strobe & i_pb) | (~i_imc_strobe & st_r.imc_b);
    st_nxt.imc_c = (i_imc_strobe & i_pc) | (~i_imc_strobe & st_r.imc_c);
    if (wr) begin
      case (i_bus.addr)
        `REG_OUT_A: st_nxt.out_a = i_bus.wdata; // see R2
        `REG_OUT_B: st_nxt.out_b = i_bus.wdata;
        `REG_OUT_C: st_nxt.out_c = i_bus.wdata;
        `REG_OUT_D: st_nxt.out_d = i_bus.wdata[2:0]; // see R19
        `REG_DIR_A: st_nxt.dir_a = i_bus.wdata;
        `REG_DIR_B: st_nxt.dir_b = i_bus.wdata;
        `REG_DIR_C: st_nxt.dir_c = i_bus.wdata;
        `REG_DIR_D: st_nxt.dir_d = i_bus.wdata[2:0];
        `REG_MODE_A: st_nxt.mode_a = i_bus.wdata;
        `REG_MODE_B: st_nxt.mode_b = i_bus.wdata;
        `REG_DRV_A: st_nxt.drv_a = i_bus.wdata;
        `REG_DRV_B: st_nxt.drv_b = i_bus.wdata;
        `REG_DRV_C: st_nxt.drv_c = i_bus.wdata;
        `REG_DRV_D: st_nxt.drv_d = i_bus.wdata[2:0];
        `REG_OMC_AB: st_nxt.omc_low = (st_r.mask_low & st_nxt.omc_low) | (~st_r.mask_low & i_bus.wdata); // see R3 see R4
        `REG_OMC_BC: st_nxt.omc_high = (st_r.mask_high & st_nxt.omc_high) | (~st_r.mask_high & i_bus.wdata);
        `REG_MASK_AB: st_nxt.mask_low = i_bus.wdata;
        `REG_MASK_BC: st_nxt.mask_high = i_bus.wdata;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // Read data registered; unmapped reads give zero
    st_nxt.rdata = `RST_BYTE;
    if (rd) begin
      case (i_bus.addr)
        `REG_IN_A: st_nxt.rdata = i_pa; // see R1
        `REG_IN_B: st_nxt.rdata = i_pb;
        `REG_IN_C: st_nxt.rdata = i_pc;
        `REG_IN_D: st_nxt.rdata = {5'h00, i_pd}; // see R19
        `REG_OUT_A: st_nxt.rdata = st_r.out_a;
        `REG_OUT_B: st_nxt.rdata = st_r.out_b;
        `REG_OUT_C: st_nxt.rdata = st_r.out_c;
        `REG_OUT_D: st_nxt.rdata = {5'h00, st_r.out_d};
        `REG_DIR_A: st_nxt.rdata = st_r.dir_a;
        `REG_DIR_B: st_nxt.rdata = st_r.dir_b;
        `REG_DIR_C: st_nxt.rdata = st_r.dir_c;
        `REG_DIR_D: st_nxt.rdata = {5'h00, st_r.dir_d};
        `REG_MODE_A: st_nxt.rdata = st_r.mode_a;
        `REG_MODE_B: st_nxt.rdata = st_r.mode_b;
        `REG_DRV_A: st_nxt.rdata = st_r.drv_a;
        `REG_DRV_B: st_nxt.rdata = st_r.drv_b;
        `REG_DRV_C: st_nxt.rdata = st_r.drv_c;
        `REG_DRV_D: st_nxt.rdata = {5'h00, st_r.drv_d};
        `REG_OMC_AB: st_nxt.rdata = st_r.omc_low; // see R3 see R7
        `REG_OMC_BC: st_nxt.rdata = st_r.omc_high;
        `REG_MASK_AB: st_nxt.rdata = st_r.mask_low;
        `REG_MASK_BC: st_nxt.rdata = st_r.mask_high;
        `REG_IMC_A: st_nxt.rdata = st_r.imc_a; // see R5
        `REG_IMC_B: st_nxt.rdata = st_r.imc_b;
        `REG_IMC_C: st_nxt.rdata = st_r.imc_c;
        `REG_OE_A: st_nxt.rdata = drv_st_a; // see R6
        `REG_OE_B: st_nxt.rdata = drv_st_b;
        `REG_OE_C: st_nxt.rdata = drv_st_c;
        default: st_nxt.rdata = `RST_BYTE;
      endcase
    end
  end
  // Everything clears at power-up
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0; // see R20 see R4 see R17 see R18
    end else begin
      st_r <= st_nxt;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  AST_IN_READ: assert property (rd && i_bus.addr == `REG_IN_A |=> o_rdata == $past(i_pa)) // see R1
    else $error("input read mismatch");
  AST_OUT_BACK: assert property (wr && i_bus.addr == `REG_OUT_B ##1 rd && i_bus.addr == `REG_OUT_B
    |=> o_rdata == $past(i_bus.wdata, 2)) // see R2
    else $error("output latch readback wrong");
  AST_MASK_BLOCK: assert property (wr && i_bus.addr == `REG_OMC_AB && !i_cell_clk_en[7] &&
    st_r.mask_low[7] |=> $stable(st_r.omc_low[7])) // see R4
    else $error("masked cell loaded");
  AST_CELL_LOAD: assert property (wr && i_bus.addr == `REG_OMC_BC && !st_r.mask_high[7]
    |=> st_r.omc_high[7] == $past(i_bus.wdata[7])) // see R3
    else $error("cell not loaded");
  AST_PD_ZERO: assert property (rd && i_bus.addr == `REG_OUT_D |=> o_rdata[7:3] == 5'h00) // see R19
    else $error("port d upper bits nonzero");
  AST_DIR_DRIVE: assert property (st_r.dir_b[2] && !st_r.mode_b[2] && !st_r.drv_b[6]
    |-> o_pb_oe[2] && o_pb[2] == (csel_b[2] ? cell_b[2] : st_r.out_b[2])) // see R2
    else $error("direction output not driven");
  AST_CS_OE: assert property (o_pd_oe == (i_oe_term_d | st_r.dir_d)) // see R15
    else $error("chip select enable wrong");
  AST_CSI_BLOCK: assert property (i_pd[2] && i_bus.sel && i_bus.wr && i_bus.addr == `REG_DIR_A
    |=> $stable(st_r.dir_a)) // see R13
    else $error("write taken while deselected");
  COV_CELL_WR: cover property (wr && i_bus.addr == `REG_OMC_AB);
  COV_PD_READ: cover property (rd && i_bus.addr == `REG_IN_D);
  COV_PERIPH: cover property (i_peripheral_mode && i_periph_select);
endmodule // port_data_block
`default_nettype wire

// ---- rtl/port_data_regs.svh ----
// Overview of operation
// R1: Input reads return live pin levels
// R2: Output latch holds, reads back, drives pins
// R3: Cell reads flops; writes load unmasked flops
// R4: Mask bit one blocks loads, resets zero
// R5: Input cells latch pins, feed array, readable
// R6: Enable readback shows per-pin driver state
// R7: Cell registers only on ports A-C
// R8: Low cells to A/B, high to B/C
// R9: A/B low nibble slew, high open-drain
// R10: Port A alone data bus, peripheral mode
// R11: Port C no address out, test port
// R12: Port D three pins, direct array inputs
// R13: Port D strobe, clock, chip select
// R14: Chip selects one term, selectable polarity
// R15: Chip select enabled by term or direction
// R16: Power-down holds, undefined or tri-states pins
// R17: Direction one outputs, resets to input
// R18: Mode bit zero I/O, one address
// R19: Port D upper five bits read zero
// R20: Data and mask registers clear at power-up
`ifndef PORT_DATA_REGS_SVH
`define PORT_DATA_REGS_SVH
// ----------------------------------------
// Register offsets within the io block
// ----------------------------------------
`define REG_IN_A 8'h00
`define REG_IN_B 8'h01
`define REG_IN_C 8'h10
`define REG_IN_D 8'h11
`define REG_OUT_A 8'h04
`define REG_OUT_B 8'h05
`define REG_OUT_C 8'h12
`define REG_OUT_D 8'h13
`define REG_DIR_A 8'h06
`define REG_DIR_B 8'h07
`define REG_DIR_C 8'h14
`define REG_DIR_D 8'h15
`define REG_MODE_A 8'h02
`define REG_MODE_B 8'h03
`define REG_DRV_A 8'h08
`define REG_DRV_B 8'h09
`define REG_DRV_C 8'h16
`define REG_DRV_D 8'h17
`define REG_OMC_AB 8'h20
`define REG_OMC_BC 8'h21
`define REG_MASK_AB 8'h22
`define REG_MASK_BC 8'h23
`define REG_IMC_A 8'h0A
`define REG_IMC_B 8'h0B
`define REG_IMC_C 8'h18
`define REG_OE_A 8'h0C
`define REG_OE_B 8'h0D
`define REG_OE_C 8'h1A
// ----------------------------------------
// Values and field masks
// ----------------------------------------
`define RST_BYTE 8'h00
`define PORT_D_MASK 8'h07
`define LOW_NIBBLE 8'h0F
`define HIGH_NIBBLE 8'hF0
`endif

// ---- rtl/port_data_pkg.sv ----
package port_data_pkg;
  // Bus request carried as one group
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_s;
  // Per-port pin routing choice for logic cells
  typedef enum logic {
    ROUTE_LOW_GROUP,
    ROUTE_HIGH_GROUP
  } route_sel_e;
endpackage

// ---- rtl/port_pin_slice.sv ----
`timescale 1ns/1ps
`default_nettype none
// One eight-bit pin group: output mux, enable, drive mode
module port_pin_slice (
  input wire logic [7:0] i_latch,
  input wire logic [7:0] i_cell,
  input wire logic [7:0] i_cell_sel,
  input wire logic [7:0] i_addr_out,
  input wire logic [7:0] i_addr_sel,
  input wire logic [7:0] i_dir,
  input wire logic [7:0] i_oe_term,
  input wire logic [7:0] i_open_drain,
  input wire logic [7:0] i_tristate,
  output logic [7:0] o_level,
  output logic [7:0] o_oe,
  output logic [7:0] o_drv_state
);
  logic [7:0] level;
  logic [7:0] drive;
  // Address out wins, then logic cells, then latch
  always_comb begin
    level = i_addr_sel & i_addr_out | ~i_addr_sel & (i_cell_sel & i_cell | ~i_cell_sel & i_latch);
    drive = (i_dir | i_oe_term | i_addr_sel) & ~i_tristate; // see R2 see R17 see R16
    o_level = level;
    // Open-drain only pulls low; high is left to the pull-up
    o_oe = drive & ~(i_open_drain & level); // see R9
    o_drv_state = drive; // see R6
  end
endmodule // port_pin_slice
`default_nettype wire

// ---- dv/port_pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-side pin model for one port
// ----------------------------------------
module port_pin_partner #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_dut_level,
  input wire logic [W-1:0] i_dut_oe,
  input wire logic [W-1:0] i_ext_level,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_pin
);
  logic [W-1:0] last_r = '0;
  // Undriven bits flip each cycle so a stale level never reads as valid
  always_comb begin
    for (int b = 0; b < W; b++) begin
      o_pin[b] = i_dut_oe[b] ? i_dut_level[b] : (i_ext_en[b] ? i_ext_level[b] : ~last_r[b]);
    end
  end
  // Last wire level, kept only to build the released pattern
  always_ff @(posedge i_clk) begin
    last_r <= o_pin;
  end
endmodule // port_pin_partner
`default_nettype wire

// ---- dv/test_port_data_and_pin_functions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "port_data_regs.svh"
module test_port_data_and_pin_functions;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  port_data_pkg::bus_req_s i_bus;
  logic [7:0] o_rdata, i_pa, i_pb, i_pc, o_pa, o_pa_oe, o_pb, o_pb_oe, o_pc, o_pc_oe;
  logic [7:0] o_pa_fast_slew, o_pb_fast_slew, i_address_out, i_cell_clk_en;
  logic [7:0] i_cell_group_low_d, i_cell_group_high_d, o_output_cell_group_low;
  logic [7:0] o_output_cell_group_high, i_route_low_to_b, i_route_high_to_c;
  logic [7:0] i_oe_term_a, i_oe_term_b, i_oe_term_c, i_imc_strobe, i_mcu_data;
  logic [2:0] i_pd, o_pd, o_pd_oe, o_pd_fast_slew, i_oe_term_d, i_cs_term;
  logic [2:0] i_cs_active_high, i_cs_enable;
  logic i_data_port_mode, i_peripheral_mode, i_periph_select, i_test_port_en;
  logic i_data_byte_enable_en, i_power_down_active, o_address_strobe, o_logic_clock_in;
  logic o_data_byte_enable, o_chip_select_n, o_mem_disable;
  logic [23:0] o_array_inputs;
  logic [7:0] ext_a, ext_b, ext_c, ext_en;
  logic [2:0] ext_d;
  int failures = 0;
  int checks = 0;
  // Rows of address, write value, expected read-back
  localparam logic [23:0] ROWS [8] = '{{`REG_OUT_A, 8'h5A, 8'h5A}, {`REG_OUT_B, 8'hA5, 8'hA5},
    {`REG_OUT_C, 8'h3C, 8'h3C}, {`REG_OUT_D, 8'hFF, 8'h07}, {`REG_MASK_AB, 8'hF0, 8'hF0},
    {`REG_MASK_BC, 8'h0F, 8'h0F}, {`REG_DIR_C, 8'h81, 8'h81}, {`REG_OE_C, 8'hFF, 8'h81}};
  localparam logic [7:0] RST_REGS [9] = '{`REG_OUT_A, `REG_OUT_D, `REG_DIR_A, `REG_MODE_A,
    `REG_MASK_AB, `REG_MASK_BC, `REG_OMC_AB, `REG_OE_A, `REG_IMC_A};
  port_data_block dut (.*);
  // Pin wires for each port, the design's drive winning over the outside
  port_pin_partner #(.W(8)) pin_a (.i_clk(i_clk), .i_dut_level(o_pa), .i_dut_oe(o_pa_oe),
    .i_ext_level(ext_a), .i_ext_en(ext_en), .o_pin(i_pa));
  port_pin_partner #(.W(8)) pin_b (.i_clk(i_clk), .i_dut_level(o_pb), .i_dut_oe(o_pb_oe),
    .i_ext_level(ext_b), .i_ext_en(ext_en), .o_pin(i_pb));
  port_pin_partner #(.W(8)) pin_c (.i_clk(i_clk), .i_dut_level(o_pc), .i_dut_oe(o_pc_oe),
    .i_ext_level(ext_c), .i_ext_en(ext_en), .o_pin(i_pc));
  port_pin_partner #(.W(3)) pin_d (.i_clk(i_clk), .i_dut_level(o_pd), .i_dut_oe(o_pd_oe),
    .i_ext_level(ext_d), .i_ext_en(ext_en[2:0]), .o_pin(i_pd));
  // ----------------------------------------
  // Clock, compare and bus tasks
  // ----------------------------------------
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp_rdata(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t rdata got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access cycle; request held for one edge, then dropped
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_bus <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_bus <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    i_bus <= '0;
    #1;
    cmp_rdata(o_rdata, exp);
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge i_clk);
    failures++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_bus = '0;
    {i_address_out, i_cell_clk_en, i_cell_group_low_d, i_cell_group_high_d} = '0;
    {i_route_low_to_b, i_route_high_to_c, i_oe_term_a, i_oe_term_b, i_oe_term_c} = '0;
    {i_oe_term_d, i_cs_term, i_cs_active_high, i_cs_enable, i_imc_strobe, i_mcu_data} = '0;
    {i_data_port_mode, i_peripheral_mode, i_periph_select, i_test_port_en} = '0;
    {i_data_byte_enable_en, i_power_down_active, ext_a, ext_b, ext_c, ext_d} = '0;
    ext_en = 8'hFF;
    // Low cells to B, high cells to C, so port A pins show the latch
    i_route_low_to_b = 8'hFF;
    i_route_high_to_c = 8'hFF;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    foreach (RST_REGS[i]) rd(RST_REGS[i], 8'h00);
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    // Direction and enable term both switch the driver on
    wr(`REG_DIR_A, 8'hFF);
    #1;
    cmp_pin(o_pa, 8'h5A);
    cmp_pin(o_pa_oe, 8'hFF);
    rd(`REG_OE_A, 8'hFF);
    rd(`REG_IN_A, 8'h5A);
    i_oe_term_b <= 8'h0F;
    @(posedge i_clk);
    #1;
    cmp_pin(o_pb_oe, 8'h0F);
    i_oe_term_b <= 8'h00;
    // Live pin levels, then an input cell capture
    ext_b <= 8'hC3;
    rd(`REG_IN_B, 8'hC3);
    ext_b <= 8'h96;
    rd(`REG_IN_B, 8'h96);
    i_imc_strobe <= 8'hFF;
    @(posedge i_clk);
    i_imc_strobe <= 8'h00;
    ext_b <= 8'h00;
    rd(`REG_IMC_B, 8'h96);
    cmp_pin(o_array_inputs[15:8], 8'h96);
    // Masked bits keep their flops clear: upper in AB, lower in BC
    wr(`REG_OMC_AB, 8'hFF);
    rd(`REG_OMC_AB, 8'h0F);
    cmp_pin(o_output_cell_group_low, 8'h0F);
    cmp_pin(o_pb, 8'h0F);
    wr(`REG_OMC_BC, 8'hFF);
    rd(`REG_OMC_BC, 8'hF0);
    cmp_pin(o_pc, 8'hF0);
    // Chip select high refuses accesses
    ext_d <= 3'b100;
    @(posedge i_clk);
    #1;
    cmp_pin({7'h00, o_mem_disable}, 8'h01);
    wr(`REG_OUT_B, 8'h00);
    wr(`REG_DIR_A, 8'h00);
    ext_d <= 3'b000;
    rd(`REG_OUT_B, 8'hA5);
    rd(`REG_DIR_A, 8'hFF);
    rd(8'hFF, 8'h00);
    // Write then read back to back, no idle cycle between
    @(posedge i_clk);
    i_bus <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: `REG_OUT_B, wdata: 8'h69};
    @(posedge i_clk);
    i_bus <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: `REG_OUT_B, wdata: 8'h00};
    @(posedge i_clk);
    i_bus <= '0;
    #1;
    cmp_rdata(o_rdata, 8'h69);
    // Power-down tri-states the data port, other pins hold
    i_data_port_mode <= 1'b1;
    i_power_down_active <= 1'b1;
    @(posedge i_clk);
    #1;
    cmp_pin(o_pa_oe, 8'h00);
    cmp_pin(o_pc_oe, 8'h81);
    i_data_port_mode <= 1'b0;
    i_power_down_active <= 1'b0;
    // External chip select, both polarities
    wr(`REG_DIR_D, 8'h01);
    i_cs_enable <= 3'b001;
    i_cs_term <= 3'b001;
    @(posedge i_clk);
    #1;
    cmp_pin({5'h00, o_pd_oe}, 8'h01);
    cmp_pin({7'h00, o_pd[0]}, 8'h00);
    i_cs_active_high <= 3'b001;
    @(posedge i_clk);
    #1;
    cmp_pin({7'h00, o_pd[0]}, 8'h01);
    // Direction bit alone turns one port B driver on
    wr(`REG_DIR_B, 8'h04);
    #1;
    cmp_pin(o_pb_oe, 8'h04);
    // Mid-run reset clears every register again
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`REG_OUT_A, 8'h00);
    rd(`REG_MASK_AB, 8'h00);
    rd(`REG_OMC_BC, 8'h00);
    cmp_pin(o_pb_oe, 8'h00);
    tally_and_finish();
  end
endmodule // test_port_data_and_pin_functions
`default_nettype wire
